/* common/oms_pkg.sv */
package oms_pkg;
	localparam int unsigned OMS_CLK_HZ = 20_000_000;
	// extra turret drive after the in limit, in milliseconds
	localparam int unsigned OMS_OVERDRIVE_MS = 1000;
	localparam int unsigned OMS_OVERDRIVE_CYC =
		(OMS_CLK_HZ / 1000) * OMS_OVERDRIVE_MS;
	// debounce settle time, in microseconds
	localparam int unsigned OMS_DEBOUNCE_US = 5000;
	localparam int unsigned OMS_DEBOUNCE_CYC =
		(OMS_CLK_HZ / 1_000_000) * OMS_DEBOUNCE_US;
	localparam int unsigned OMS_NUM_IN = 9;

	typedef enum logic [1:0] {
		OMS_MAG_LOW = 2'h0,
		OMS_MAG_UNIT = 2'h1,
		OMS_MAG_HIGH = 2'h2
	} oms_mag_t;

	// one motor drive: enable and direction (1 = in / back)
	typedef struct packed {
		logic en;
		logic dir;
	} oms_drive_t;

	typedef struct packed {
		logic low_power_button;
		logic unit_power_button;
		logic high_power_button;
	} oms_buttons_t;

	typedef struct packed {
		logic low_lens_in_limit;
		logic low_lens_out_limit;
		logic high_lens_in_limit;
		logic high_lens_out_limit;
		logic tube_back_limit;
		logic tube_fwd_limit;
	} oms_limits_t;

	typedef struct packed {
		logic low_power;
		logic unit_power;
		logic high_power;
	} oms_lamps_t;
endpackage

/* rtl/oms_debounce.sv */
`timescale 1ns/100ps
module oms_debounce
	import oms_pkg::*;
#(
	parameter int unsigned WIDTH = OMS_NUM_IN,
	parameter int unsigned SETTLE_CYC = OMS_DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// raw and clean levels
	input wire logic [WIDTH-1:0] raw_i,
	output logic [WIDTH-1:0] clean_o
);
	localparam int unsigned CW = $clog2(SETTLE_CYC + 1);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_ch
			logic sync1;
			logic sync2;
			logic [CW-1:0] cnt;
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					sync1 <= 1'b0;
					sync2 <= 1'b0;
				end else begin
					sync1 <= raw_i[g];
					sync2 <= sync1;
				end
			end
			// level must hold steady before it is accepted
			always_ff @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					cnt <= '0;
					clean_o[g] <= 1'b0;
				end else if (sync2 == clean_o[g]) begin
					cnt <= '0;
				end else if (cnt == CW'(SETTLE_CYC - 1)) begin
					cnt <= '0;
					clean_o[g] <= sync2;
				end else begin
					cnt <= cnt + 1'b1;
				end
			end
		end
	endgenerate
endmodule

/* rtl/oms_sequencer.sv */
`timescale 1ns/100ps
// Operation
// R1 - each element has two positions, each sensed by a binary limit input.
// R2 - when idle exactly one lamp, matching the element positions, is lit; the code lights none while idle at an unknown position.
// R3 - pressing a dark button drives every element needing change.
// R4 - a press is held as a request until its motion has finished.
// R5 - all lamps stay dark while anything moves.
// R6 - presses while all lamps are dark are ignored; the code takes them while idle at an unknown position.
// R7 - low to high drives turret in, clutch on and slide out together.
// R8 - turret keeps driving one second after its in limit trips.
// R9 - each drive runs on until its own limit trips, independent of others.
// R10 - slide out limit drops clutch and slide motor together.
// R11 - no travel timeouts; any transit time and arrival order completes.
// R12 - new lamp lights only after all targets are reached and motion stops.
// R13 - unit to high moves tube back before turret entry begins.
// R14 - high to unit moves turret out before tube forward begins.
// R15 - targets: low=in/out/back, unit=out/out/fwd, high=out/in/back.
// R16 - inputs are synchronised and debounced; overdrive is a counter.
// R17 - each drive has enable and direction and never both directions.
module oms_sequencer
	import oms_pkg::*;
#(
	parameter int unsigned OVERDRIVE_CYC = OMS_OVERDRIVE_CYC,
	parameter int unsigned SETTLE_CYC = OMS_DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// operator buttons and limit switches
	input wire oms_buttons_t buttons_i,
	input wire oms_limits_t limits_i,
	// drives
	output oms_drive_t slide_o,
	output logic slide_clutch_drive_o,
	output oms_drive_t turret_o,
	output oms_drive_t tube_o,
	// indicators
	output oms_lamps_t lamps_o,
	output logic busy_o
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_STAGE1 = 4'b0010,
		ST_STAGE2 = 4'b0100,
		ST_SETTLE = 4'b1000
	} oms_state_t;

	localparam int unsigned OW = $clog2(OVERDRIVE_CYC + 1);

	oms_buttons_t btn;
	oms_limits_t lim;
	oms_state_t state;
	oms_state_t next_state;
	oms_mag_t high_power_request_latch;
	logic turret_in_command;
	logic turret_overdrive_delay;
	logic [OW-1:0] od_cnt;
	logic slide_out_hold;
	logic slide_in_hold;
	logic turret_out_hold;
	logic tube_back_hold;
	logic tube_fwd_hold;
	logic high_power_transition_active;
	logic any_press;
	oms_mag_t pressed;
	oms_mag_t cur_mag;
	logic cur_valid;
	logic all_stopped;
	logic at_target;
	logic stage1_done;

	oms_debounce #(
		.WIDTH(OMS_NUM_IN),
		.SETTLE_CYC(SETTLE_CYC)
	) u_deb (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.raw_i({buttons_i, limits_i}),
		.clean_o({btn, lim})
	); // [R16]

	// decode current magnification from limit states [R1] [R15]
	function automatic logic mag_match(input oms_limits_t l,
			input oms_mag_t m);
		case (m)
			OMS_MAG_LOW: mag_match = l.low_lens_in_limit &&
				l.high_lens_out_limit && l.tube_back_limit;
			OMS_MAG_UNIT: mag_match = l.low_lens_out_limit &&
				l.high_lens_out_limit && l.tube_fwd_limit;
			OMS_MAG_HIGH: mag_match = l.low_lens_out_limit &&
				l.high_lens_in_limit && l.tube_back_limit;
			default: mag_match = 1'b0;
		endcase
	endfunction

	always_comb begin
		cur_valid = 1'b1;
		if (mag_match(lim, OMS_MAG_LOW)) begin
			cur_mag = OMS_MAG_LOW;
		end else if (mag_match(lim, OMS_MAG_UNIT)) begin
			cur_mag = OMS_MAG_UNIT;
		end else if (mag_match(lim, OMS_MAG_HIGH)) begin
			cur_mag = OMS_MAG_HIGH;
		end else begin
			cur_mag = OMS_MAG_LOW;
			cur_valid = 1'b0;
		end
		// priority high, unit, low on simultaneous presses
		any_press = 1'b1;
		if (btn.high_power_button) begin
			pressed = OMS_MAG_HIGH;
		end else if (btn.unit_power_button) begin
			pressed = OMS_MAG_UNIT;
		end else if (btn.low_power_button) begin
			pressed = OMS_MAG_LOW;
		end else begin
			pressed = OMS_MAG_LOW;
			any_press = 1'b0;
		end
		// a lit button's own press is not a request [R3]
		if (cur_valid && pressed == cur_mag) begin
			any_press = 1'b0;
		end
	end

	assign all_stopped = !(slide_out_hold || slide_in_hold ||
		turret_in_command || turret_overdrive_delay || turret_out_hold ||
		tube_back_hold || tube_fwd_hold);
	assign at_target = mag_match(lim, high_power_request_latch);
	// judged on limits: the stage-one holds reload from the limits on every ST_STAGE1 cycle
	assign stage1_done =
		(lim.tube_back_limit || high_power_request_latch == OMS_MAG_UNIT) &&
		(lim.high_lens_out_limit ||
		high_power_request_latch == OMS_MAG_HIGH);
	assign high_power_transition_active = (state != ST_IDLE);

	// sequencing; no travel timeout anywhere [R11]
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (any_press) begin
					next_state = ST_STAGE1; // [R3]
				end
			end
			ST_STAGE1: begin
				// tube back and turret out must land before the second stage; slide is not waited for [R13] [R14]
				if (stage1_done) begin
					next_state = ST_STAGE2;
				end
			end
			ST_STAGE2: begin
				if (all_stopped) begin
					next_state = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				next_state = at_target ? ST_IDLE : ST_STAGE1; // [R12]
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// held request, only taken while idle [R4] [R6]
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			high_power_request_latch <= OMS_MAG_LOW;
		end else if (state == ST_IDLE && any_press) begin
			high_power_request_latch <= pressed;
		end
	end

	// per-element holds; each clears on its own limit or on return to ST_IDLE [R9]
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			slide_out_hold <= 1'b0;
			slide_in_hold <= 1'b0;
			tube_back_hold <= 1'b0;
			turret_out_hold <= 1'b0;
		end else if (state == ST_IDLE) begin
			slide_out_hold <= 1'b0;
			slide_in_hold <= 1'b0;
			tube_back_hold <= 1'b0;
			turret_out_hold <= 1'b0;
		end else if (state == ST_STAGE1) begin
			// slide moves in the first stage alongside turret [R7]
			slide_out_hold <= high_power_request_latch != OMS_MAG_LOW &&
				!lim.low_lens_out_limit; // [R10]
			slide_in_hold <= high_power_request_latch == OMS_MAG_LOW &&
				!lim.low_lens_in_limit;
			tube_back_hold <= high_power_request_latch != OMS_MAG_UNIT &&
				!lim.tube_back_limit; // [R13]
			turret_out_hold <= high_power_request_latch != OMS_MAG_HIGH &&
				!lim.high_lens_out_limit; // [R14]
		end else begin
			if (lim.low_lens_out_limit) slide_out_hold <= 1'b0; // [R10]
			if (lim.low_lens_in_limit) slide_in_hold <= 1'b0;
		end
	end

	// second stage: turret in, or tube forward
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			turret_in_command <= 1'b0;
			tube_fwd_hold <= 1'b0;
		end else if (state == ST_STAGE1 && next_state == ST_STAGE2) begin
			turret_in_command <= high_power_request_latch == OMS_MAG_HIGH &&
				!lim.high_lens_in_limit; // [R7] [R13]
			tube_fwd_hold <= high_power_request_latch == OMS_MAG_UNIT &&
				!lim.tube_fwd_limit; // [R14]
		end else begin
			if (lim.high_lens_in_limit) turret_in_command <= 1'b0;
			if (lim.tube_fwd_limit) tube_fwd_hold <= 1'b0;
		end
	end

	// overdrive: keep turret running after in limit trips [R8]
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			turret_overdrive_delay <= 1'b0;
			od_cnt <= '0;
		end else if (turret_in_command) begin
			turret_overdrive_delay <= 1'b1;
			od_cnt <= OW'(OVERDRIVE_CYC);
		end else if (turret_overdrive_delay) begin
			if (od_cnt <= OW'(1)) begin
				turret_overdrive_delay <= 1'b0;
				od_cnt <= '0;
			end else begin
				od_cnt <= od_cnt - 1'b1;
			end
		end
	end

	// stage-one holds also stop on their own limits
	logic tube_back_done;
	logic turret_out_done;
	assign tube_back_done = lim.tube_back_limit;
	assign turret_out_done = lim.high_lens_out_limit;

	// outputs registered; one direction per drive [R17]
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			slide_o <= '0;
			slide_clutch_drive_o <= 1'b0;
			turret_o <= '0;
			tube_o <= '0;
		end else begin
			slide_o.en <= slide_out_hold || slide_in_hold;
			slide_o.dir <= slide_in_hold;
			slide_clutch_drive_o <= slide_out_hold || slide_in_hold; // [R10]
			turret_o.en <= turret_overdrive_delay ||
				(turret_out_hold && !turret_out_done);
			turret_o.dir <= turret_overdrive_delay;
			tube_o.en <= (tube_back_hold && !tube_back_done) || tube_fwd_hold;
			tube_o.dir <= !tube_fwd_hold;
		end
	end

	// lamps: dark while busy, one lit when idle at a known position
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			lamps_o <= '0;
			busy_o <= 1'b0;
		end else begin
			busy_o <= high_power_transition_active;
			if (high_power_transition_active || any_press) begin
				lamps_o <= '0; // [R5] [R12]
			end else begin
				lamps_o.low_power <= cur_valid && cur_mag == OMS_MAG_LOW; // [R2]
				lamps_o.unit_power <= cur_valid && cur_mag == OMS_MAG_UNIT;
				lamps_o.high_power <= cur_valid && cur_mag == OMS_MAG_HIGH;
			end
		end
	end
endmodule

/* testbench/oms_sequencer_asserts.sv */
`timescale 1ns/100ps
module oms_sequencer_asserts
	import oms_pkg::*;
#(
	parameter int unsigned OVERDRIVE_CYC = OMS_OVERDRIVE_CYC,
	parameter int unsigned SETTLE_CYC = OMS_DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// watched ports
	input wire oms_buttons_t buttons_i,
	input wire oms_limits_t limits_i,
	input wire oms_drive_t slide_o,
	input wire logic slide_clutch_drive_o,
	input wire oms_drive_t turret_o,
	input wire oms_drive_t tube_o,
	input wire oms_lamps_t lamps_o,
	input wire logic busy_o
);
	localparam int STOP = SETTLE_CYC + 8;
	logic [31:0] od_cnt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// cycles of turret drive past the in limit
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			od_cnt <= 32'h0000_0000;
		else if (turret_o.en && turret_o.dir && limits_i.high_lens_in_limit)
			od_cnt <= od_cnt + 32'h0000_0001;
		else
			od_cnt <= 32'h0000_0000;
	end
	sequence s_slide_out; slide_o.en && !slide_o.dir; endsequence
	sequence s_turret_in; turret_o.en && turret_o.dir; endsequence
	property p_clutch; slide_clutch_drive_o == slide_o.en; endproperty
	property p_od_min;
		$fell(turret_o.en) && $past(turret_o.dir) &&
			$past(limits_i.high_lens_in_limit) |-> od_cnt >= OVERDRIVE_CYC;
	endproperty
	property p_od_max; od_cnt <= OVERDRIVE_CYC + SETTLE_CYC + 8; endproperty
	property p_slide_stop;
		s_slide_out ##0 limits_i.low_lens_out_limit |-> ##[1:STOP] !slide_o.en;
	endproperty
	property p_tube_first; s_turret_in |-> limits_i.tube_back_limit; endproperty
	property p_turret_first;
		tube_o.en && !tube_o.dir |-> limits_i.high_lens_out_limit;
	endproperty
	property p_dark; busy_o |-> lamps_o == 3'h0; endproperty
	property p_onehot; lamps_o != 3'h0 |-> $onehot(lamps_o); endproperty
	property p_still;
		lamps_o != 3'h0 |-> !(slide_o.en || turret_o.en || tube_o.en);
	endproperty
	property p_fell_busy; $fell(busy_o) |-> ##[0:2] lamps_o != 3'h0; endproperty
	a_clutch: assert property (p_clutch)
		else $error("clutch differs from slide motor");
	a_od_min: assert property (p_od_min)
		else $error("turret stopped before overdrive ran out");
	a_od_max: assert property (p_od_max)
		else $error("turret overdrive too long");
	a_slide_stop: assert property (p_slide_stop)
		else $error("slide did not stop at out limit");
	a_tube_first: assert property (p_tube_first)
		else $error("turret entry before tube back");
	a_turret_first: assert property (p_turret_first)
		else $error("tube forward before turret out");
	a_dark: assert property (p_dark)
		else $error("lamp lit while busy");
	a_onehot: assert property (p_onehot)
		else $error("more than one lamp lit");
	a_still: assert property (p_still)
		else $error("lamp lit while a drive runs");
	a_fell_busy: assert property (p_fell_busy)
		else $error("no lamp after move finished");
endmodule

bind oms_sequencer oms_sequencer_asserts #(
	.OVERDRIVE_CYC(OVERDRIVE_CYC),
	.SETTLE_CYC(SETTLE_CYC)
) u_chk (
	.clk_i(clk_i),
	.sys_rst_i(sys_rst_i),
	.buttons_i(buttons_i),
	.limits_i(limits_i),
	.slide_o(slide_o),
	.slide_clutch_drive_o(slide_clutch_drive_o),
	.turret_o(turret_o),
	.tube_o(tube_o),
	.lamps_o(lamps_o),
	.busy_o(busy_o)
);

/* testbench/oms_optics_model.sv */
`timescale 1ns/100ps
module oms_optics_model
	import oms_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// drives and transit times
	input wire oms_drive_t slide_i,
	input wire oms_drive_t turret_i,
	input wire oms_drive_t tube_i,
	input wire logic [17:0] dly_i,
	// limit switches
	output oms_limits_t limits_o
);
	// index 2 slide, 1 turret, 0 tube; pos 1 = in / back
	logic [2:0] pos;
	logic [2:0] moving;
	logic [5:0] cnt [3];
	oms_drive_t drv [3];
	assign drv[2] = slide_i;
	assign drv[1] = turret_i;
	assign drv[0] = tube_i;
	// element leaves its limit while travelling
	assign limits_o = {pos[2] & !moving[2], !pos[2] & !moving[2],
		pos[1] & !moving[1], !pos[1] & !moving[1],
		pos[0] & !moving[0], !pos[0] & !moving[0]};
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pos <= 3'h5;
			moving <= 3'h0;
			for (int i = 0; i < 3; i++)
				cnt[i] <= 6'h00;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (drv[i].en && drv[i].dir != pos[i]) begin
					moving[i] <= 1'b1;
					cnt[i] <= cnt[i] + 6'h01;
					if (cnt[i] == dly_i[i*6 +: 6]) begin
						pos[i] <= drv[i].dir;
						moving[i] <= 1'b0;
						cnt[i] <= 6'h00;
					end
				end
			end
		end
	end
endmodule

/* testbench/tb_optics_magnification_sequencer.sv */
`timescale 1ns/100ps
module tb_optics_magnification_sequencer
	import oms_pkg::*;
;
	localparam int unsigned OD = 20;
	localparam int unsigned ST = 4;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	oms_buttons_t buttons = 3'h0;
	logic [17:0] dly = 18'h3_ffff;
	oms_limits_t limits;
	oms_drive_t slide, turret, tube;
	logic clutch, busy;
	oms_lamps_t lamps;
	int num_errors = 0;
	int total_checks = 0;
	logic [7:0] lf = 8'h23;
	oms_mag_t cur, tgt, oth;
	always #25 clk_i = ~clk_i;
	oms_sequencer #(.OVERDRIVE_CYC(OD), .SETTLE_CYC(ST)) dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .buttons_i(buttons),
		.limits_i(limits), .slide_o(slide), .slide_clutch_drive_o(clutch),
		.turret_o(turret), .tube_o(tube), .lamps_o(lamps), .busy_o(busy));
	oms_optics_model u_optics (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.slide_i(slide), .turret_i(turret), .tube_i(tube), .dly_i(dly),
		.limits_o(limits));
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic [5:0] exp_lamps(input oms_mag_t m);
		return {3'h0, m == OMS_MAG_LOW, m == OMS_MAG_UNIT, m == OMS_MAG_HIGH};
	endfunction
	function automatic oms_limits_t exp_limits(input oms_mag_t m);
		case (m)
			OMS_MAG_LOW: return 6'h26;
			OMS_MAG_UNIT: return 6'h15;
			default: return 6'h1a;
		endcase
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#5;
	endtask
	task automatic chk(input string what, input logic [5:0] e,
		input logic [5:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	task automatic press(input oms_mag_t m);
		buttons = 3'h4 >> m;
		tick(ST + 6);
		buttons = 3'h0;
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		tick(40000);
		num_errors++;
		give_verdict();
	end
	initial begin
		for (int r = 0; r < 2; r++) begin
			sys_rst_i = 1'b1;
			tick(8);
			sys_rst_i = 1'b0;
			cur = OMS_MAG_LOW;
			tick(ST + 6);
			chk("lamps after reset", exp_lamps(cur), {3'h0, lamps});
			for (int t = 0; t < 12; t++) begin
				lf = lfsr_next(lf);
				dly = {lf[5:0] | 6'h20, lf[7:2] | 6'h20, lf[6:1] | 6'h20};
				tgt = oms_mag_t'(2'(lf % 8'h03));
				oth = oms_mag_t'(2'((lf + 8'h01) % 8'h03));
				press(tgt);
				tick(ST + 4);
				if (tgt == cur) begin
					chk("busy on lit press", 6'h00, {5'h00, busy});
				end else begin
					chk("busy held", 6'h01, {5'h00, busy});
					chk("lamps moving", 6'h00, {3'h0, lamps});
					press(oth);
					for (int i = 0; i < 2000 && busy !== 1'b0; i++)
						tick(1);
					chk("busy end", 6'h00, {5'h00, busy});
					cur = tgt;
				end
				tick(3);
				chk("lamps", exp_lamps(cur), {3'h0, lamps});
				chk("limits", exp_limits(cur), limits);
				$display("test %0d.%0d done, magnification %0d", r, t, cur);
			end
		end
		give_verdict();
	end
endmodule
